//--- hdl/dmd_top.sv
// Functional notes
// - Lower 128 bytes at 00-7F reachable by direct and indirect modes.
// - Upper 128 bytes at 80-FF reachable only by indirect mode and stack pushes and pops.
// - Special register space at 80-FF reachable only by direct mode.
// - Above 7F, direct goes to registers, indirect to upper RAM.
// - On-chip xdata RAM of 256 or 768 bytes via external move, bit clear.
// - On-chip xdata RAM occupies lowest external data addresses.
// - With bit clear, index-register moves and pointer moves within on-chip range target on-chip RAM.
// - On-chip xdata access leaves low port and both strobes untouched.
// - High address port shows its output register except while a pointer-move bus cycle drives the pointer high byte.
// - With bit clear, pointer moves above on-chip range run a bus cycle.
// - With bit set, index moves put 8-bit address on low port.
// - With bit set, pointer moves put high byte on high port.
// - With bit set, every external move strobes read or write.
// - Stack pushes and pops reach only the 256-byte internal RAM.

`timescale 1ns/1ps
`include "dmd_cfg.svh"
module dmd_top
  import dmd_pkg::*;
#(
  parameter int XRAM_BYTES = `DMD_XRAM_SMALL,
  parameter int PHASE_CYC = `DMD_PHASE_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,

  // CPU request and answer
  input wire logic req_i,
  input wire dmd_req_t req_data_i,
  output logic ready_o,
  output logic ack_o,
  output logic [7:0] rdata_o,

  // Control
  input wire logic internal_xdata_disable_i,
  input wire logic [7:0] high_port_reg_i,

  // Special register space
  output logic sfr_req_o,
  output logic sfr_we_o,
  output logic [7:0] sfr_addr_o,
  output logic [7:0] sfr_wdata_o,
  input wire logic [7:0] sfr_rdata_i,

  // External bus pins
  input wire logic [7:0] low_port_i,
  output logic [7:0] low_port_o,
  output logic low_port_oe_o,
  output logic [7:0] high_port_o,
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o
);

  localparam int XAW = $clog2(XRAM_BYTES);
  localparam int IAW = $clog2(`DMD_IRAM_BYTES);

  ////////////////////////////////////////////////////////////////////////////
  // Routing of one request.

  function automatic dmd_tgt_t dmd_route(input dmd_kind_t k,
                                         input logic [15:0] a,
                                         input logic xdis);
    dmd_route = DMD_T_IRAM;
    case (k)
      DMD_K_DIRECT: begin
        if (a[`DMD_UPPER_BIT]) begin
          dmd_route = DMD_T_SFR;
        end
      end
      DMD_K_XRI: begin
        dmd_route = xdis ? DMD_T_XBUS : DMD_T_XRAM;
      end
      DMD_K_XDPTR: begin
        if (!xdis && (a < 16'(XRAM_BYTES))) begin
          dmd_route = DMD_T_XRAM;
        end else begin
          dmd_route = DMD_T_XBUS;
        end
      end
      default: dmd_route = DMD_T_IRAM;
    endcase
  endfunction : dmd_route

  logic busy_q, stage_q, ack_q;
  dmd_tgt_t tgt_q;
  logic [7:0] rdata_q, high_q;
  logic sfr_req_q, sfr_we_q;
  logic [7:0] sfr_addr_q, sfr_wdata_q;

  // The route is settled from kind, address and the disable bit in the
  // take cycle, so no strobe can start before the choice is made.
  wire take = req_i && !busy_q;
  wire dmd_tgt_t tgt = dmd_route(req_data_i.kind, req_data_i.addr,
                                 internal_xdata_disable_i);
  wire wide = (req_data_i.kind == DMD_K_XDPTR);
  wire [15:0] xaddr = wide ? req_data_i.addr
                           : {8'h00, req_data_i.addr[7:0]};
  wire iram_en = take && (tgt == DMD_T_IRAM);
  wire xram_en = take && (tgt == DMD_T_XRAM);
  wire xb_start = take && (tgt == DMD_T_XBUS);
  wire [IAW-1:0] iram_addr = req_data_i.addr[IAW-1:0];
  wire [XAW-1:0] xram_addr = xaddr[XAW-1:0];

  logic [7:0] iram_rd, xram_rd, xb_rd;
  logic xb_done, xb_hi_drv;
  logic [7:0] xb_hi;

  ////////////////////////////////////////////////////////////////////////////
  // Storage: lower and upper RAM share one array, indexed by 8 bits.

  dmd_ram #(
    .DEPTH(`DMD_IRAM_BYTES),
    .AW(IAW)
  ) u_iram (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .en_i(iram_en),
    .we_i(req_data_i.we),
    .addr_i(iram_addr),
    .wdata_i(req_data_i.wdata),
    .rdata_o(iram_rd)
  );

  dmd_ram #(
    .DEPTH(XRAM_BYTES),
    .AW(XAW)
  ) u_xram (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .en_i(xram_en),
    .we_i(req_data_i.we),
    .addr_i(xram_addr),
    .wdata_i(req_data_i.wdata),
    .rdata_o(xram_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // External bus cycle.

  dmd_xbus #(
    .PHASE_CYC(PHASE_CYC)
  ) u_xbus (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .start_i(xb_start),
    .wide_i(wide),
    .we_i(req_data_i.we),
    .addr_i(xaddr),
    .wdata_i(req_data_i.wdata),
    .done_o(xb_done),
    .rdata_o(xb_rd),
    .low_port_i(low_port_i),
    .low_port_o(low_port_o),
    .low_port_oe_o(low_port_oe_o),
    .hi_drv_o(xb_hi_drv),
    .hi_addr_o(xb_hi),
    .ale_o(ale_o),
    .rd_n_o(rd_n_o),
    .wr_n_o(wr_n_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request tracking and answer.

  // Internal targets answer two cycles after the take; the bus answers
  // one cycle after its sequencer reaches the hold state.
  // Only one access is in flight, which keeps ordering trivial at the cost
  // of throughput on back-to-back internal accesses.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      stage_q <= 1'b0;
      ack_q <= 1'b0;
      tgt_q <= DMD_T_IRAM;
      rdata_q <= 8'h00;
    end else begin
      ack_q <= 1'b0;
      stage_q <= take && (tgt != DMD_T_XBUS);
      if (take) begin
        busy_q <= 1'b1;
        tgt_q <= tgt;
      end
      if (stage_q) begin
        ack_q <= 1'b1;
        busy_q <= 1'b0;
        case (tgt_q)
          DMD_T_SFR: rdata_q <= sfr_rdata_i;
          DMD_T_XRAM: rdata_q <= xram_rd;
          default: rdata_q <= iram_rd;
        endcase
      end else if (xb_done) begin
        ack_q <= 1'b1;
        busy_q <= 1'b0;
        rdata_q <= xb_rd;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sfr_req_q <= 1'b0;
      sfr_we_q <= 1'b0;
      sfr_addr_q <= 8'h00;
      sfr_wdata_q <= 8'h00;
      high_q <= 8'h00;
    end else begin
      sfr_req_q <= take && (tgt == DMD_T_SFR);
      if (take) begin
        sfr_we_q <= req_data_i.we;
        sfr_addr_q <= req_data_i.addr[7:0];
        sfr_wdata_q <= req_data_i.wdata;
      end
      high_q <= high_port_reg_i;
    end
  end

  // The pointer's high byte wins only while a wide bus cycle runs.
  assign high_port_o = xb_hi_drv ? xb_hi : high_q;
  assign ready_o = !busy_q;
  assign ack_o = ack_q;
  assign rdata_o = rdata_q;
  assign sfr_req_o = sfr_req_q;
  assign sfr_we_o = sfr_we_q;
  assign sfr_addr_o = sfr_addr_q;
  assign sfr_wdata_o = sfr_wdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  lower_reach_a: assert property (
    take && req_data_i.kind == DMD_K_DIRECT && !req_data_i.addr[7]
    |=> !sfr_req_o && !ale_o ##1 ack_o)
    else $error("Direct lower access misrouted.");

  upper_indirect_a: assert property (
    take && req_data_i.kind == DMD_K_INDIRECT
    |=> !sfr_req_o && !ale_o ##1 ack_o)
    else $error("Indirect access left internal RAM.");

  sfr_direct_a: assert property (
    take && req_data_i.kind == DMD_K_DIRECT && req_data_i.addr[7]
    |=> sfr_req_o && sfr_addr_o == $past(req_data_i.addr[7:0]))
    else $error("Direct upper access missed register space.");

  xram_quiet_a: assert property (
    take && !internal_xdata_disable_i && (req_data_i.kind == DMD_K_XRI ||
    (wide && req_data_i.addr < 16'(XRAM_BYTES)))
    |=> (!ale_o && rd_n_o && wr_n_o && !low_port_oe_o)[*2] ##0 ack_o)
    else $error("On-chip xdata access disturbed the bus.");

  xbus_start_a: assert property (
    xb_start |=> ale_o && low_port_oe_o && rd_n_o && wr_n_o &&
    low_port_o == $past(xaddr[7:0]))
    else $error("Bus cycle did not open with address.");

  high_wide_a: assert property (
    xb_start && wide |=> high_port_o == $past(req_data_i.addr[15:8]))
    else $error("High port lacks pointer high byte.");

  high_page_a: assert property (
    xb_start && !wide |=> high_port_o == $past(high_port_reg_i))
    else $error("High port lost its output register value.");

  write_strobe_a: assert property (
    xb_start && req_data_i.we |-> ##[1:40] !wr_n_o)
    else $error("Write strobe missing.");

  read_strobe_a: assert property (
    xb_start && !req_data_i.we |-> ##[1:40] !rd_n_o)
    else $error("Read strobe missing.");

  stack_internal_a: assert property (
    take && req_data_i.kind == DMD_K_STACK
    |=> !sfr_req_o && !ale_o ##1 ack_o)
    else $error("Stack access left internal RAM.");

  idle_quiet_a: assert property (
    ready_o |-> !ale_o && rd_n_o && wr_n_o && !low_port_oe_o)
    else $error("Bus active while no access is in flight.");

  sfr_pulse_a: assert property (
    sfr_req_o |=> !sfr_req_o)
    else $error("Register space request lasted too long.");

  bus_answer_a: assert property (
    $rose(rd_n_o) || $rose(wr_n_o) |=> ack_o)
    else $error("Strobe ended without an answer.");

  above_xram_a: assert property (
    take && wide && !internal_xdata_disable_i &&
    req_data_i.addr >= 16'(XRAM_BYTES) |=> ale_o && !ready_o)
    else $error("Pointer move above on-chip range stayed inside.");

endmodule : dmd_top

//--- hdl/dmd_cfg.svh
`ifndef DMD_CFG_SVH
`define DMD_CFG_SVH

// Byte counts of the internal data spaces.
`define DMD_IRAM_BYTES 256
`define DMD_XRAM_SMALL 256
`define DMD_XRAM_LARGE 768

// Bit of an 8-bit internal address that splits lower from upper space.
`define DMD_UPPER_BIT 7

// Cycles spent in each of the address and strobe phases of a bus cycle.
`define DMD_PHASE_CYC 2

// Width of the external-move address and of the phase counter.
`define DMD_ADDR_W 16
`define DMD_CNT_W 4

`endif

//--- hdl/dmd_pkg.sv
package dmd_pkg;

  // How the CPU reaches its operand.
  typedef enum logic [2:0] {
    DMD_K_DIRECT,
    DMD_K_INDIRECT,
    DMD_K_STACK,
    DMD_K_XRI,
    DMD_K_XDPTR
  } dmd_kind_t;

  // Where an access ends up.
  typedef enum logic [1:0] {
    DMD_T_IRAM,
    DMD_T_SFR,
    DMD_T_XRAM,
    DMD_T_XBUS
  } dmd_tgt_t;

  // External bus sequencer states.
  typedef enum logic [1:0] {
    DMD_XB_IDLE,
    DMD_XB_ADDR,
    DMD_XB_STRB,
    DMD_XB_HOLD
  } dmd_xb_st_t;

  // One CPU request.
  typedef struct packed {
    dmd_kind_t kind;
    logic [15:0] addr;
    logic we;
    logic [7:0] wdata;
  } dmd_req_t;

endpackage : dmd_pkg

//--- hdl/dmd_ram.sv
`timescale 1ns/1ps
module dmd_ram
  import dmd_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Access port
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);

  logic [7:0] mem_q [DEPTH];
  logic [7:0] rdata_q;

  // The array carries no reset so that it maps onto plain RAM cells.
  always_ff @(posedge mclk_i) begin
    if (en_i && we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else if (en_i && !we_i) begin
      rdata_q <= mem_q[addr_i];
    end
  end

  assign rdata_o = rdata_q;

endmodule : dmd_ram

//--- hdl/dmd_xbus.sv
`timescale 1ns/1ps
`include "dmd_cfg.svh"
module dmd_xbus
  import dmd_pkg::*;
#(
  parameter int PHASE_CYC = `DMD_PHASE_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Request from the decoder
  input wire logic start_i,
  input wire logic wide_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic done_o,
  output logic [7:0] rdata_o,
  // Pins
  input wire logic [7:0] low_port_i,
  output logic [7:0] low_port_o,
  output logic low_port_oe_o,
  output logic hi_drv_o,
  output logic [7:0] hi_addr_o,
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o
);

  dmd_xb_st_t st_q;
  logic [`DMD_CNT_W-1:0] cnt_q;
  logic [7:0] sync1_q, sync2_q, lo_q, hi_q, wd_q;
  logic oe_q, ale_q, rd_n_q, wr_n_q, hi_drv_q, we_q;
  wire last = (cnt_q == `DMD_CNT_W'(PHASE_CYC - 1));

  // Two stages before the bus data is used.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= low_port_i;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= DMD_XB_IDLE;
      cnt_q <= '0;
      {lo_q, hi_q, wd_q} <= 24'h00_0000;
      {oe_q, ale_q, hi_drv_q, we_q} <= 4'h0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end else begin
      case (st_q)
        DMD_XB_IDLE: if (start_i) begin
          st_q <= DMD_XB_ADDR;
          cnt_q <= '0;
          ale_q <= 1'b1;
          oe_q <= 1'b1;
          lo_q <= addr_i[7:0];
          hi_q <= addr_i[15:8];
          hi_drv_q <= wide_i;
          we_q <= we_i;
          wd_q <= wdata_i;
        end
        DMD_XB_ADDR: if (last) begin
          st_q <= DMD_XB_STRB;
          cnt_q <= '0;
          ale_q <= 1'b0;
          oe_q <= we_q;
          lo_q <= wd_q;
          rd_n_q <= we_q;
          wr_n_q <= !we_q;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
        DMD_XB_STRB: if (last) begin
          st_q <= DMD_XB_HOLD;
          rd_n_q <= 1'b1;
          wr_n_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
        DMD_XB_HOLD: begin
          st_q <= DMD_XB_IDLE;
          oe_q <= 1'b0;
          hi_drv_q <= 1'b0;
        end
        default: st_q <= DMD_XB_IDLE;
      endcase
    end
  end

  assign done_o = (st_q == DMD_XB_HOLD);
  // Read data come from the second stage, which at the answer edge holds
  // the pin as it stood in the strobe; PHASE_CYC must be at least 2.
  assign rdata_o = sync2_q;
  assign low_port_o = lo_q;
  assign low_port_oe_o = oe_q;
  assign hi_drv_o = hi_drv_q;
  assign hi_addr_o = hi_q;
  assign ale_o = ale_q;
  assign rd_n_o = rd_n_q;
  assign wr_n_o = wr_n_q;

  ////////////////////////////////////////////////////////////////////////////
  strobe_excl_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !(!rd_n_o && !wr_n_o) && !(ale_o && (!rd_n_o || !wr_n_o)))
    else $error("Both strobes or strobe with latch enable.");

endmodule : dmd_xbus

//--- bench/dmd_xmem.sv
`timescale 1ns/1ps
module dmd_xmem (
  // Clock
  input wire logic mclk_i,
  // Bus pins seen from the memory side
  input wire logic ale_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] pin_i,
  input wire logic [7:0] hi_i,
  // Read drive and bookkeeping
  output logic [7:0] data_o,
  output logic [15:0] addr_o,
  output int strobes_o
);
  logic [7:0] mem_q [0:65535];
  logic [7:0] last_q = 8'h00;
  logic [15:0] addr_q = 16'h0000;
  int cnt_q = 0;
  logic rd_q = 1'b1;
  logic wr_q = 1'b1;

  assign addr_o = addr_q;
  assign strobes_o = cnt_q;

  // A released line shows the inverse of its last value, so a read that
  // samples too late or too early cannot pass by luck.
  assign data_o = rd_n_i ? ~last_q : mem_q[addr_q];

  always @(posedge mclk_i) begin
    if (ale_i) begin
      addr_q <= {hi_i, pin_i};
    end
    if (!wr_n_i) begin
      mem_q[addr_q] <= pin_i;
    end
    if ((!rd_n_i && rd_q) || (!wr_n_i && wr_q)) begin
      cnt_q <= cnt_q + 1;
    end
    rd_q <= rd_n_i;
    wr_q <= wr_n_i;
    last_q <= data_o;
  end
endmodule : dmd_xmem

//--- bench/tb_dmd_top.sv
`timescale 1ns/1ps
module tb_dmd_top;
  import dmd_pkg::*;
  localparam int P = 2;
  localparam int XB = 256;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_i = 1'b0;
  dmd_req_t req_data_i = '0;
  logic xdis = 1'b0;
  logic [7:0] hreg = 8'h12;
  logic ready_o, ack_o, low_port_oe_o, ale_o, rd_n_o, wr_n_o;
  logic sfr_req_o, sfr_we_o;
  logic [7:0] rdata_o, sfr_addr_o, sfr_wdata_o, low_port_o, high_port_o;
  logic [7:0] xm_data;
  logic [15:0] xm_addr;
  logic [15:0] rd;
  logic [15:0] sfr_wlog = 16'h0000;
  int xm_strobes;
  int errors = 0;
  int num_checks = 0;
  int sfr_cnt = 0;
  int lat;
  int s0;
  logic bus_seen;
  wire [7:0] pin = low_port_oe_o ? low_port_o : xm_data;
  wire [7:0] sfr_rdata = ~sfr_addr_o;

  dmd_top #(.XRAM_BYTES(XB), .PHASE_CYC(P)) u_dmd_top (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req_i),
    .req_data_i(req_data_i), .ready_o(ready_o), .ack_o(ack_o),
    .rdata_o(rdata_o), .internal_xdata_disable_i(xdis),
    .high_port_reg_i(hreg), .sfr_req_o(sfr_req_o), .sfr_we_o(sfr_we_o),
    .sfr_addr_o(sfr_addr_o), .sfr_wdata_o(sfr_wdata_o),
    .sfr_rdata_i(sfr_rdata), .low_port_i(pin), .low_port_o(low_port_o),
    .low_port_oe_o(low_port_oe_o), .high_port_o(high_port_o),
    .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o));

  dmd_xmem u_dmd_xmem (
    .mclk_i(mclk_i), .ale_i(ale_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
    .pin_i(pin), .hi_i(high_port_o), .data_o(xm_data),
    .addr_o(xm_addr), .strobes_o(xm_strobes));

  initial forever #2.5 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    if (sfr_req_o === 1'b1) begin
      sfr_cnt <= sfr_cnt + 1;
      if (sfr_we_o === 1'b1) begin
        sfr_wlog <= {sfr_addr_o, sfr_wdata_o};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // One CPU access; returns read data in rd and the answer cycle in lat.
  task automatic acc(input dmd_kind_t k, input logic [15:0] a,
                     input logic w, input logic [7:0] d);
    int n;
    n = 0;
    bus_seen = 1'b0;
    check({15'h0, ready_o}, 16'h0001);
    req_i = 1'b1;
    req_data_i = '{kind: k, addr: a, we: w, wdata: d};
    do begin
      @(posedge mclk_i);
      #1;
      req_i = 1'b0;
      n++;
      if (ale_o !== 1'b0 || rd_n_o !== 1'b1 || wr_n_o !== 1'b1 ||
          low_port_oe_o !== 1'b0) begin
        bus_seen = 1'b1;
      end
    end while (ack_o !== 1'b1 && n < 40);
    if (ack_o !== 1'b1) begin
      errors++;
      end_sim();
    end else begin
      lat = n;
      rd = {8'h00, rdata_o};
    end
  endtask : acc

  //////////////////////////////////////////////////////////////////////////
  task automatic t_low;
    acc(DMD_K_DIRECT, 16'h0005, 1'b1, 8'ha5);
    check(16'(lat), 16'h0002);
    acc(DMD_K_INDIRECT, 16'h0005, 1'b0, 8'h00);
    check(rd, 16'h00a5);
    acc(DMD_K_INDIRECT, 16'h007f, 1'b1, 8'h3c);
    acc(DMD_K_DIRECT, 16'h007f, 1'b0, 8'h00);
    check(rd, 16'h003c);
    check(16'(sfr_cnt), 16'h0000);
    $display("t_low done");
  endtask : t_low

  task automatic t_split;
    acc(DMD_K_INDIRECT, 16'h00a0, 1'b1, 8'h5a);
    check(16'(sfr_cnt), 16'h0000);
    acc(DMD_K_DIRECT, 16'h00a0, 1'b0, 8'h00);
    check(rd, 16'h005f);
    check(16'(sfr_cnt), 16'h0001);
    acc(DMD_K_DIRECT, 16'h00a0, 1'b1, 8'h33);
    check(sfr_wlog, 16'ha033);
    acc(DMD_K_INDIRECT, 16'h00a0, 1'b0, 8'h00);
    check(rd, 16'h005a);
    $display("t_split done");
  endtask : t_split

  task automatic t_xram;
    s0 = xm_strobes;
    acc(DMD_K_XRI, 16'hffa0, 1'b1, 8'h77);
    check(16'(lat), 16'h0002);
    check({15'h0, bus_seen}, 16'h0000);
    acc(DMD_K_XDPTR, 16'h00a0, 1'b0, 8'h00);
    check(rd, 16'h0077);
    acc(DMD_K_XDPTR, 16'(XB - 1), 1'b1, 8'h4b);
    check({15'h0, bus_seen}, 16'h0000);
    acc(DMD_K_STACK, 16'h00ff, 1'b1, 8'he1);
    acc(DMD_K_XRI, 16'h00ff, 1'b0, 8'h00);
    check(rd, 16'h004b);
    acc(DMD_K_INDIRECT, 16'h00ff, 1'b0, 8'h00);
    check(rd, 16'h00e1);
    check(16'(xm_strobes - s0), 16'h0000);
    hreg = 8'h34;
    repeat (2) @(posedge mclk_i);
    #1;
    check({8'h00, high_port_o}, 16'h0034);
    hreg = 8'h12;
    $display("t_xram done");
  endtask : t_xram

  task automatic t_bus_clear;
    s0 = xm_strobes;
    acc(DMD_K_XDPTR, 16'(XB), 1'b1, 8'h3c);
    check(16'(lat), 16'(2 * P + 2));
    check({8'h00, u_dmd_xmem.mem_q[XB]}, 16'h003c);
    acc(DMD_K_XDPTR, 16'(XB), 1'b0, 8'h00);
    check(rd, 16'h003c);
    check(16'(xm_strobes - s0), 16'h0002);
    $display("t_bus_clear done");
  endtask : t_bus_clear

  task automatic t_bus_set;
    xdis = 1'b1;
    @(posedge mclk_i);
    #1;
    s0 = xm_strobes;
    acc(DMD_K_XRI, 16'h00a0, 1'b1, 8'h99);
    check({8'h00, u_dmd_xmem.mem_q[16'h12a0]}, 16'h0099);
    acc(DMD_K_XRI, 16'h00a0, 1'b0, 8'h00);
    check(rd, 16'h0099);
    acc(DMD_K_XDPTR, 16'h00a0, 1'b1, 8'h66);
    check({8'h00, u_dmd_xmem.mem_q[16'h00a0]}, 16'h0066);
    acc(DMD_K_XDPTR, 16'h1234, 1'b1, 8'h81);
    check(xm_addr, 16'h1234);
    acc(DMD_K_XDPTR, 16'h1234, 1'b0, 8'h00);
    check(rd, 16'h0081);
    check(16'(xm_strobes - s0), 16'h0005);
    xdis = 1'b0;
    @(posedge mclk_i);
    #1;
    acc(DMD_K_XRI, 16'h00a0, 1'b0, 8'h00);
    check(rd, 16'h0077);
    $display("t_bus_set done");
  endtask : t_bus_set

  task automatic t_reset;
    hreg = 8'h56;
    rst_n_i = 1'b0;
    #1;
    check({rdata_o, high_port_o}, 16'h0000);
    check({12'h000, ack_o, ale_o, rd_n_o, wr_n_o}, 16'h0003);
    check({14'h0000, ready_o, low_port_oe_o}, 16'h0002);
    @(posedge mclk_i);
    #1;
    rst_n_i = 1'b1;
    @(posedge mclk_i);
    #1;
    check({8'h00, high_port_o}, 16'h0056);
    hreg = 8'h12;
    acc(DMD_K_INDIRECT, 16'h007f, 1'b0, 8'h00);
    check(rd, 16'h003c);
    $display("t_reset done");
  endtask : t_reset

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk_i);
    #1;
    rst_n_i = 1'b1;
    t_low();
    t_split();
    t_xram();
    t_bus_clear();
    t_bus_set();
    t_reset();
    end_sim();
  end
endmodule : tb_dmd_top
